// *** verilog/otpc_consts.svh ***
// constants for the security-register / page-size serial controller
// assumes a 20 MHz ref clock and a serial flash port driven as a spi master
// Function
// - select falls while serial clock high
// - command bytes shifted msb first, falling edge
// - program opcode 0x9b then three 0x00
// - host sends 64 user bytes from zero
// - select rises on falling clock edge
// - read opcode 0x77 plus three dummies
// - host may stop read early
// - page-size command 3d 2a 80 a6
// - host waits programming time after page-size
// - recheck bit 0, reissue if unset (not done here: no status read command)
`ifndef OTPC_CONSTS_SVH
`define OTPC_CONSTS_SVH
`define OTPC_OP_SEC_PROG   8'h9b
`define OTPC_OP_SEC_READ   8'h77
`define OTPC_OP_PAGE_B0    8'h3d
`define OTPC_OP_PAGE_B1    8'h2a
`define OTPC_OP_PAGE_B2    8'h80
`define OTPC_OP_PAGE_B3    8'ha6
`define OTPC_PAD_BYTE      8'h00
`define OTPC_USER_BYTES    64
`define OTPC_REG_BYTES     128
`define OTPC_CLK_NS        50
`define OTPC_SCK_HALF      4
`define OTPC_PROG_TIME_US  4000
`define OTPC_PROG_CYCLES   ((`OTPC_PROG_TIME_US * 1000) / `OTPC_CLK_NS)
`define OTPC_CMD_LEN       4
`endif

// *** verilog/otpc_pkg.sv ***
// types for the security-register / page-size serial controller
// assumes otpc_consts.svh is compiled alongside
package otpc_pkg;
   // command kinds offered on the user port
   typedef enum logic [1:0] {
      OTPC_CMD_PROG,
      OTPC_CMD_READ,
      OTPC_CMD_PAGE
   } otpc_cmd_e;
   typedef logic [7:0] otpc_byte_t;
endpackage

// *** verilog/otpc_stream_if.sv ***
// valid/ready byte stream between the controller and its buffer
// assumes both ends on the same clock
`timescale 1ns/1ns
interface otpc_stream_if;
   logic [7:0] data;   // byte
   logic       valid;  // byte present
   logic       ready;  // byte accepted
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// *** verilog/otpc_skid_buf.sv ***
// two-entry valid/ready buffer for received read bytes
// assumes one clock; a stalled sink holds bytes without loss
`timescale 1ns/1ns
module otpc_skid_buf #(
   parameter int DEPTH = 2               // entries
) (
   input  wire logic ref_clk_in,         // clock
   input  wire logic rst_n_in,           // async reset, low
   otpc_stream_if.snk fill,              // from shifter
   otpc_stream_if.src drain              // to user
);
   logic [7:0] mem_reg [DEPTH];          // storage
   logic [$clog2(DEPTH):0] cnt_reg;      // fill level
   logic [$clog2(DEPTH)-1:0] wr_reg;     // write slot
   logic [$clog2(DEPTH)-1:0] rd_reg;     // read slot
   logic push;                           // write this cycle
   logic pop;                            // read this cycle

   assign fill.ready  = (cnt_reg != DEPTH[$clog2(DEPTH):0]);
   assign drain.valid = (cnt_reg != '0);
   assign drain.data  = mem_reg[rd_reg];
   assign push = fill.valid & fill.ready;
   assign pop  = drain.valid & drain.ready;

   // storage writes, no reset needed on data
   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem_reg[wr_reg] <= fill.data;
      end
   end

   // pointers and level
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_reg <= '0;
         wr_reg  <= '0;
         rd_reg  <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
      end
   end

   // never more bytes than slots
   a_buf_no_overflow: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      cnt_reg <= DEPTH) else $error("buffer overflow");
endmodule

// *** verilog/otpc_ctrl.sv ***
// host controller: security register program/read and page-size command
// assumes an spi-like flash port; serial clock made here by a divider
`timescale 1ns/1ns
`include "otpc_consts.svh"
module otpc_ctrl import otpc_pkg::*; #(
   parameter int PROG_CYCLES = `OTPC_PROG_CYCLES,  // programming wait
   parameter int HALF        = `OTPC_SCK_HALF      // sck half period
) (
   input  wire logic       ref_clk_in,      // 20 mhz clock
   input  wire logic       rst_n_in,        // async reset, low
   input  wire logic       start_in,        // start a command, pulse
   input  wire otpc_cmd_e  cmd_in,          // command kind
   input  wire logic [7:0] read_len_in,     // read bytes, 0 means 128
   input  wire logic [7:0] wdata_in,        // program byte
   input  wire logic       wvalid_in,       // program byte present
   output      logic       wready_out,      // program byte taken
   output      logic [7:0] rdata_out,       // read byte
   output      logic       rvalid_out,      // read byte present
   input  wire logic       rready_in,       // read byte accepted
   output      logic       busy_out,        // command or wait active
   output      logic       sck_out,         // serial clock to flash
   output      logic       select_n_out,    // flash select, low
   output      logic       mosi_out,        // data to flash
   input  wire logic       miso_in          // data from flash
);
   typedef enum logic [2:0] {S_IDLE, S_SHIFT, S_GAP, S_END, S_WAIT} otpc_state_e;

   otpc_state_e state_reg;          // sequencer state
   otpc_cmd_e   cmd_reg;            // latched command
   logic [7:0]  tx_reg;             // outgoing shift
   logic [7:0]  next_reg;           // byte waiting for its first fall
   logic [7:0]  rx_reg;             // incoming shift
   logic [2:0]  bit_reg;            // bit in byte
   logic [7:0]  byte_reg;           // byte count in frame
   logic [7:0]  total_reg;          // bytes in frame
   logic [7:0]  div_reg;            // half-period count
   logic [31:0] wait_reg;           // programming timer
   logic        miso_m_reg;         // sync stage one
   logic        miso_s_reg;         // sync stage two
   logic        sck_reg;            // serial clock
   logic        half_done;          // half period over
   otpc_stream_if rx_if ();         // shifter to buffer
   otpc_stream_if user_if ();       // buffer to user

   // command byte for position n of the four-byte header
   function automatic logic [7:0] hdr_byte(input otpc_cmd_e c, input logic [1:0] n);
      case (c)
         OTPC_CMD_PROG: hdr_byte = (n == 2'd0) ? `OTPC_OP_SEC_PROG : `OTPC_PAD_BYTE;
         OTPC_CMD_READ: hdr_byte = (n == 2'd0) ? `OTPC_OP_SEC_READ : `OTPC_PAD_BYTE;
         default: begin
            case (n)
               2'd0:    hdr_byte = `OTPC_OP_PAGE_B0;
               2'd1:    hdr_byte = `OTPC_OP_PAGE_B1;
               2'd2:    hdr_byte = `OTPC_OP_PAGE_B2;
               default: hdr_byte = `OTPC_OP_PAGE_B3;
            endcase
         end
      endcase
   endfunction

   // sck half-period tick, then handshake and pin outputs
   assign half_done = (div_reg == 8'(HALF - 1));
   // program data taken when loading a payload byte at a byte boundary
   assign wready_out = (state_reg == S_GAP) && (cmd_reg == OTPC_CMD_PROG) &&
                       (byte_reg >= 8'(`OTPC_CMD_LEN)) && (byte_reg < total_reg);
   assign busy_out     = (state_reg != S_IDLE);
   assign sck_out      = sck_reg;
   assign select_n_out = (state_reg == S_IDLE) || (state_reg == S_WAIT);
   assign mosi_out     = tx_reg[7];
   assign rdata_out    = user_if.data;
   assign rvalid_out   = user_if.valid;
   assign user_if.ready = rready_in;

   // miso passes two flops before use
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         miso_m_reg <= 1'b1;
         miso_s_reg <= 1'b1;
      end else begin
         miso_m_reg <= miso_in;
         miso_s_reg <= miso_m_reg;
      end
   end

   // two entries, so a stalled reader costs no byte
   otpc_skid_buf #(.DEPTH(2)) u_buf (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .fill       (rx_if),
      .drain      (user_if)
   );

   // main sequencer; sck idles high so select falls with clock high
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= S_IDLE;
         cmd_reg   <= OTPC_CMD_READ;
         tx_reg    <= 8'hff;
         next_reg  <= 8'hff;
         rx_reg    <= 8'h00;
         bit_reg   <= 3'd0;
         byte_reg  <= 8'h00;
         total_reg <= 8'h00;
         div_reg   <= 8'h00;
         wait_reg  <= '0;
         sck_reg   <= 1'b1;
         rx_if.valid <= 1'b0;
         rx_if.data  <= 8'h00;
      end else begin
         if (rx_if.valid && rx_if.ready) begin
            rx_if.valid <= 1'b0;
         end
         case (state_reg)
            S_IDLE: begin
               sck_reg <= 1'b1;
               div_reg <= 8'h00;
               // page command may be reissued whenever idle
               if (start_in) begin
                  cmd_reg   <= cmd_in;
                  byte_reg  <= 8'h00;
                  total_reg <= (cmd_in == OTPC_CMD_PROG) ? 8'(`OTPC_CMD_LEN + `OTPC_USER_BYTES) :
                               (cmd_in == OTPC_CMD_READ) ?
                               ((read_len_in == 8'h00 || read_len_in > 8'(`OTPC_REG_BYTES)) ?
                                8'(`OTPC_CMD_LEN + `OTPC_REG_BYTES) :
                                8'(`OTPC_CMD_LEN) + read_len_in) :
                               8'(`OTPC_CMD_LEN);
                  state_reg <= S_GAP;
               end
            end
            S_GAP: begin
               // load next byte; payload stalls when user has none
               // staged in next_reg so mosi only ever moves on a falling edge
               if (byte_reg < 8'(`OTPC_CMD_LEN)) begin
                  next_reg  <= hdr_byte(cmd_reg, byte_reg[1:0]);
                  bit_reg   <= 3'd0;
                  state_reg <= S_SHIFT;
               end else if (byte_reg == total_reg) begin
                  state_reg <= S_END;
               end else if (cmd_reg == OTPC_CMD_PROG) begin
                  // user bytes in order from location zero
                  if (wvalid_in) begin
                     next_reg  <= wdata_in;
                     bit_reg   <= 3'd0;
                     state_reg <= S_SHIFT;
                  end
               end else if (!rx_if.valid) begin
                  // read stops at requested length; waits on full buffer
                  next_reg  <= 8'hff;
                  bit_reg   <= 3'd0;
                  state_reg <= S_SHIFT;
               end
            end
            S_SHIFT: begin
               div_reg <= half_done ? 8'h00 : div_reg + 8'h01;
               if (half_done) begin
                  sck_reg <= ~sck_reg;
                  if (sck_reg) begin
                     // falling edge: next bit out, msb first; first fall loads byte
                     tx_reg <= (bit_reg == 3'd0) ? next_reg : {tx_reg[6:0], 1'b1};
                  end else begin
                     // rising edge: flash samples, capture miso; mosi left alone
                     rx_reg  <= {rx_reg[6:0], miso_s_reg};
                     bit_reg <= bit_reg + 3'd1;
                     if (bit_reg == 3'd7) begin
                        byte_reg <= byte_reg + 8'h01;
                        // bytes after header go to the buffer in order
                        if (cmd_reg == OTPC_CMD_READ && byte_reg >= 8'(`OTPC_CMD_LEN)) begin
                           rx_if.data  <= {rx_reg[6:0], miso_s_reg};
                           rx_if.valid <= 1'b1;
                        end
                        state_reg <= S_GAP;
                     end
                  end
               end
            end
            S_END: begin
               // select rises with the sck fall half a period after the last rise
               // rising together with sck would race the flash's sampling edge
               div_reg <= half_done ? 8'h00 : div_reg + 8'h01;
               if (half_done) begin
                  sck_reg   <= 1'b0;
                  tx_reg    <= 8'hff;
                  wait_reg  <= '0;
                  state_reg <= (cmd_reg == OTPC_CMD_READ) ? S_IDLE : S_WAIT;
               end
            end
            S_WAIT: begin
               // hold off for the programming time; sck back to idle level
               sck_reg  <= 1'b1;
               wait_reg <= wait_reg + 32'd1;
               if (wait_reg == 32'(PROG_CYCLES - 1)) begin
                  state_reg <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // select only falls with clock high
   a_sel_fall_high: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $fell(select_n_out) |-> sck_out) else $error("select fell with clock low");
   // select rises with the clock fall that ends the frame
   a_sel_rise_edge: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(select_n_out) |-> !sck_out && $past(state_reg) == S_END)
      else $error("select rose out of sequence");
   a_prog_wait_held: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (state_reg == S_WAIT) |-> select_n_out && busy_out) else $error("wait broken");
   // data only moves together with a clock fall
   a_mosi_stable: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $changed(mosi_out) |-> !sck_out) else $error("mosi changed off a falling edge");
   // the wait runs its full count before idle
   a_wait_full: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $fell(state_reg == S_WAIT) |-> $past(wait_reg) == 32'(PROG_CYCLES - 1))
      else $error("programming wait cut short");
   // program frame opens with its opcode
   a_prog_opcode: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (state_reg == S_GAP && byte_reg == 8'h00 && cmd_reg == OTPC_CMD_PROG)
      |=> next_reg == `OTPC_OP_SEC_PROG) else $error("program opcode wrong");
   // a read frame ends at the requested length
   a_read_len: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      ($rose(select_n_out) && cmd_reg == OTPC_CMD_READ) |-> byte_reg == total_reg)
      else $error("read frame length wrong");
endmodule

// *** bench/otpc_flash_model.sv ***
// behavioural flash holding the security register and page-size flag
// assumes the host drives sck, select_n and mosi; no clock of its own
`timescale 1ns/1ns
module otpc_flash_model #(
   parameter int         PROG_NS = 500,   // self-timed program length
   parameter logic [7:0] ID_BASE = 8'h5a  // identifier seed, arbitrary value
) (
   input  wire logic       sck_in,        // serial clock from host
   input  wire logic       select_n_in,   // select, low
   input  wire logic       mosi_in,       // data from host
   output      logic       miso_out,      // data to host
   output      logic       pow2_out,      // page-size flag
   output      logic [7:0] r1_errs_out,   // bad select falls seen
   output      logic [9:0] page_bytes_out, // page length in force
   output      logic       array_ok_out   // array contents still trusted
);
   logic [7:0] mem [0:127];   // security register image
   logic [7:0] buf1 [0:63];   // page buffer one
   logic [7:0] hdr [0:3];     // command header
   logic [7:0] sh;            // input shifter
   logic [7:0] status;        // bit7 ready, bit0 page size
   logic       used;          // user field already written
   int         bits;          // rises seen in frame
   int         nb;            // data bytes supplied
   assign pow2_out = status[0];
   // power-up contents
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = (i < 64) ? 8'hff : ID_BASE + i[7:0];
      status = 8'h80;
      // page length fixed at power-up from the flag, so 264 even after the flag is set
      page_bytes_out = status[0] ? 10'd256 : 10'd264;
      array_ok_out = 1'b1;
      used = 1'b0;
      miso_out = 1'b1;
      bits = 0;
      r1_errs_out = 8'h00;
   end
   always @(negedge select_n_in) begin
      bits = 0;
      hdr[0] = 8'hff;
      if (sck_in !== 1'b1) r1_errs_out = r1_errs_out + 8'h01;
   end
   // header capture, wrap at 64 into buffer one
   always @(posedge sck_in) if (select_n_in === 1'b0) begin
      sh = {sh[6:0], mosi_in};
      bits++;
      if (bits % 8 == 0 && bits <= 32) hdr[bits / 8 - 1] = sh;
      else if (bits % 8 == 0 && hdr[0] == 8'h9b) buf1[(bits / 8 - 5) % 64] = sh;
   end
   // high during header, then bytes msb first
   always @(negedge sck_in) if (select_n_in === 1'b0) begin
      if (bits >= 32 && hdr[0] == 8'h77) miso_out = mem[((bits - 32) / 8) % 128][7 - bits % 8];
      else miso_out = 1'b1;
   end
   // released line shows no stale value
   always @(posedge select_n_in) begin
      miso_out = ~miso_out;
      nb = (bits - 32) / 8;
      // self-timed, once only, unsent bytes untouched
      if (bits >= 40 && hdr[0] == 8'h9b && {hdr[1], hdr[2], hdr[3]} == 24'h0) begin
         status[7] = 1'b0;
         #PROG_NS;
         for (int i = 0; i < 64; i++) if (!used && i < nb) mem[i] = buf1[i];
         used = 1'b1;
         status[7] = 1'b1;
      end
      if (bits == 32 && {hdr[0], hdr[1], hdr[2], hdr[3]} == 32'h3d2a80a6) begin
         status[7] = 1'b0;
         #PROG_NS;
         status = 8'h81;
         // data written in the old mode is no longer trusted
         array_ok_out = 1'b0;
      end
   end
endmodule

// *** bench/otpc_ctrl_tb.sv ***
// self-checking bench for the security-register / page-size controller
// assumes otpc_flash_model on the serial side and a 20 mhz clock
`timescale 1ns/1ns
module otpc_ctrl_tb import otpc_pkg::*; ;
   localparam int PROG = 20;            // shortened programming wait
   logic       ref_clk_in  = 1'b0;      // clock
   logic       rst_n_in    = 1'b0;      // reset, low
   logic       start_in    = 1'b0;      // start pulse
   otpc_cmd_e  cmd_in      = OTPC_CMD_PROG;  // command kind
   logic [7:0] read_len_in = 8'h00;     // read length
   logic [7:0] wdata_in    = 8'h00;     // program byte
   logic       wvalid_in   = 1'b0;      // program byte valid
   logic       rready_in   = 1'b0;      // read byte ready
   logic       wready_out, rvalid_out, busy_out, sck_out, select_n_out, mosi_out, miso_in;
   logic [7:0] rdata_out;               // read byte
   logic       pow2;                    // model page-size flag
   logic [7:0] r1_errs;                 // model select-fall errors
   logic [9:0] page_bytes;              // model page length
   logic       array_ok;                // model array trusted
   logic [7:0] exp_mem [0:127];         // expected register
   int         fails = 0;               // mismatches
   int         check_count = 0;         // comparisons
   int         cycles = 0;              // timeout counter
   otpc_ctrl #(.PROG_CYCLES(PROG)) uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .start_in(start_in), .cmd_in(cmd_in), .read_len_in(read_len_in), .wdata_in(wdata_in),
      .wvalid_in(wvalid_in), .wready_out(wready_out), .rdata_out(rdata_out),
      .rvalid_out(rvalid_out), .rready_in(rready_in), .busy_out(busy_out), .sck_out(sck_out),
      .select_n_out(select_n_out), .mosi_out(mosi_out), .miso_in(miso_in));
   otpc_flash_model flash (.sck_in(sck_out), .select_n_in(select_n_out), .mosi_in(mosi_out),
      .miso_out(miso_in), .pow2_out(pow2), .r1_errs_out(r1_errs), .page_bytes_out(page_bytes),
      .array_ok_out(array_ok));
   // 50 ns clock
   always #25 ref_clk_in = ~ref_clk_in;
   // hang guard, about twice the expected run
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one-cycle start pulse
   task automatic issue(input otpc_cmd_e c, input logic [7:0] n);
      @(posedge ref_clk_in);
      #1 cmd_in = c;
      read_len_in = n;
      start_in = 1'b1;
      @(posedge ref_clk_in);
      #1 start_in = 1'b0;
   endtask
   // wait for idle, counting deselected busy cycles
   task automatic wait_idle(output int bc);
      int guard = 0;
      bc = 0;
      while (busy_out !== 1'b0 && guard < 20000) begin
         @(posedge ref_clk_in);
         guard++;
         if (select_n_out === 1'b1 && busy_out === 1'b1) bc++;
      end
      check(busy_out, 1'b0);
   endtask
   // read len bytes, receiver stalled for the first stall cycles
   task automatic t_read(input int len, input logic [7:0] n, input int stall);
      int got = 0;
      int guard = 0;
      rready_in = 1'b0;
      issue(OTPC_CMD_READ, n);
      while (guard < 20000 && !(got == len && busy_out === 1'b0)) begin
         @(posedge ref_clk_in);
         if (rvalid_out === 1'b1 && rready_in === 1'b1) begin
            check(rdata_out, exp_mem[got]);
            got++;
         end
         guard++;
         #1 rready_in = (guard > stall);
      end
      check(got, len);
      check(select_n_out, 1'b1);
   endtask
   // program 64 bytes base, base+1, ...
   task automatic t_prog(input logic [7:0] base);
      int n = 0;
      int bc;
      issue(OTPC_CMD_PROG, 8'h00);
      wdata_in = base;
      wvalid_in = 1'b1;
      while (n < 64 && cycles < 59000) begin
         @(posedge ref_clk_in);
         if (wready_out === 1'b1) begin
            n++;
            #1 wdata_in = base + n[7:0];
         end
      end
      wvalid_in = 1'b0;
      wait_idle(bc);
      check(bc >= PROG, 1'b1);
   endtask
   // page-size command, with a refused start while busy
   task automatic t_page();
      int bc;
      issue(OTPC_CMD_PAGE, 8'h00);
      issue(OTPC_CMD_READ, 8'h01);
      wait_idle(bc);
      check(bc >= PROG, 1'b1);
      check(pow2, 1'b1);
      check(page_bytes, 10'd264);
      check(array_ok, 1'b0);
      repeat (20) @(posedge ref_clk_in);
      check({select_n_out, rvalid_out}, 2'b10);
   endtask
   // main sequence
   initial begin
      for (int i = 0; i < 128; i++) exp_mem[i] = (i < 64) ? 8'hff : 8'h5a + i[7:0];
      repeat (20) @(posedge ref_clk_in);
      #1 rst_n_in = 1'b1;
      t_read(128, 8'h80, 300);
      t_prog(8'h10);
      for (int i = 0; i < 64; i++) exp_mem[i] = 8'h10 + i[7:0];
      t_read(128, 8'h00, 0);
      t_prog(8'h80);
      t_read(64, 8'h40, 0);
      t_read(3, 8'h03, 0);
      t_page();
      check(r1_errs, 8'h00);
      final_report();
   end
endmodule
